// file: ghpc_pkg.sv
package ghpc_pkg;
   // clock and timing
   localparam int CLK_MHZ          = 250;
   localparam int PULSE_HIGH_MS    = 200;
   localparam int MSG_DELAY_MS     = 300;
   localparam int SPI_IDLE_SEC     = 1;
   localparam int PULSE_HIGH_CYC   = PULSE_HIGH_MS * CLK_MHZ * 1000;
   localparam int MSG_DELAY_CYC    = MSG_DELAY_MS * CLK_MHZ * 1000;
   localparam int MIN_SATS         = 5;
   // spi idle pattern and fifo depth
   localparam logic [7:0] IDLE_B0  = 8'ha7;
   localparam logic [7:0] IDLE_B1  = 8'hb4;
   localparam int SPI_FIFO_DEPTH   = 1024;
   localparam int SPI_AW           = 10;
   // i2c defaults
   localparam int I2C_FIFO_DEPTH   = 64;
   localparam logic [6:0] I2C_RX_ADDR = 7'h60;
   localparam logic [6:0] I2C_TX_ADDR = 7'h62;
   localparam int I2C_FAST_KBPS    = 400;
   localparam int I2C_SLOW_KBPS    = 100;
   // configuration command
   localparam logic [7:0] CFG_MSG_ID  = 8'hb2;
   localparam logic [7:0] CFG_SUB_ID  = 8'h46;
   // port select encoding
   typedef enum logic [1:0] {
      GHPC_PORT_SPI  = 2'b00,
      GHPC_PORT_UART = 2'b01,
      GHPC_PORT_I2C  = 2'b10
   } ghpc_port_t;
   // power states, gray along hibernate->full->fix
   typedef enum logic [1:0] {
      GHPC_HIB  = 2'b00,
      GHPC_FULL = 2'b01,
      GHPC_FIX  = 2'b11
   } ghpc_pwr_t;
   // boot test states
   typedef enum logic [1:0] {
      GHPC_B_FLASH = 2'b00,
      GHPC_B_PIN   = 2'b01,
      GHPC_B_CRC   = 2'b11,
      GHPC_B_OP    = 2'b10
   } ghpc_boot_t;
   // fix status from navigation core
   typedef struct packed {
      logic       fix3d;
      logic [5:0] sats;
      logic       utc_sec;
      logic       fix_done;
   } ghpc_nav_t;
endpackage

// file: ghpc_top.sv
`timescale 1ns/1ps
// Function
// - power request high wakes to full power
// - power request low returns to hibernate
// - periodic mode: one pulse, one fix
// - power state output high in full and fix, low only in hibernate
// - internal or external reset clears power state machine
// - second pulse needs 3d fix, 5 sats
// - second pulse 200ms high at utc edge
// - utc message queued 300ms after pulse
// - boot tests flash, pin, crc in order
// - port lines off in reset, strap select
// - uart flow control only after config cmd
// - spi slave mode 1 up to 6.8MHz
// - spi idle pattern a7 b4 both directions
// - spi tx and rx fifos 1024 bytes
// - empty tx fifo sends idle pattern
// - rx stops after programmed idle repeats
// - fifo level interrupt, sync error, spi reset
// - i2c multi-master 400k, addresses 60/62
// - i2c fifos 64 bytes each
// - config cmd: i2c slave, 100k, new addresses
module ghpc_top
   import ghpc_pkg::*;
(
   input  wire logic            CLK_I,
   input  wire logic            RST_I,
   input  wire logic            SPI_CLK_I,
   input  wire logic            SPI_CS_N_I,
   input  wire logic            SPI_MOSI_I,
   input  wire logic            PWR_REQ_I,
   input  wire logic            EXT_RST_N_I,
   input  wire logic            PERIODIC_FIX_MODE_I,
   input  wire logic            BOOT_SELECT_IN_I,
   input  wire logic            FLASH_OK_I,
   input  wire logic            CRC_OK_I,
   input  wire logic            STRAP_A_I,
   input  wire logic            STRAP_B_I,
   input  wire ghpc_nav_t       NAV_I,
   input  wire logic            CFG_CMD_I,
   input  wire logic [7:0]      CFG_MSG_I,
   input  wire logic [7:0]      CFG_SUB_I,
   input  wire logic            CFG_I2C_SLAVE_I,
   input  wire logic            CFG_I2C_SLOW_I,
   input  wire logic [6:0]      CFG_I2C_RX_ADDR_I,
   input  wire logic [6:0]      CFG_I2C_TX_ADDR_I,
   input  wire logic            TX_WR_I,
   input  wire logic [7:0]      TX_DATA_I,
   input  wire logic            RX_RD_I,
   input  wire logic [7:0]      IDLE_LIMIT_I,
   input  wire logic [SPI_AW:0] FIFO_LEVEL_I,
   input  wire logic            SPI_SW_RST_I,
   output logic                 SPI_MISO_O,
   output logic                 SPI_MISO_OE_O,
   output logic                 POWER_STATE_O,
   output logic                 SECOND_PULSE_OUT_O,
   output logic                 UTC_MSG_O,
   output logic                 OPERATIONAL_O,
   output logic [1:0]           PORT_SEL_O,
   output logic                 PORT_EN_O,
   output logic                 UART_FLOW_EN_O,
   output logic                 I2C_SLAVE_O,
   output logic                 I2C_SLOW_O,
   output logic [6:0]           I2C_RX_ADDR_O,
   output logic [6:0]           I2C_TX_ADDR_O,
   output logic                 TX_FULL_O,
   output logic                 RX_VALID_O,
   output logic [7:0]           RX_DATA_O,
   output logic                 FIFO_IRQ_O,
   output logic                 SYNC_ERR_O
);
   // two-flop synchronisers for pins
   logic [1:0] req_sync_reg;
   logic [1:0] rstn_sync_reg;
   logic [1:0] csn_sync_reg;
   logic [1:0] bsel_sync_reg;
   logic       req_d_reg;
   always_ff @(posedge CLK_I) begin
      req_sync_reg  <= {req_sync_reg[0], PWR_REQ_I};
      rstn_sync_reg <= {rstn_sync_reg[0], EXT_RST_N_I};
      csn_sync_reg  <= {csn_sync_reg[0], SPI_CS_N_I};
      bsel_sync_reg <= {bsel_sync_reg[0], BOOT_SELECT_IN_I};
      req_d_reg     <= req_sync_reg[1];
   end
   wire req_s    = req_sync_reg[1];
   wire req_rise = req_s & ~req_d_reg;
   // internal or external reset both clear state
   wire rst = RST_I | ~rstn_sync_reg[1];

   // power state machine
   ghpc_pwr_t pwr_reg;
   ghpc_pwr_t pwr_next;
   always_comb begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         GHPC_HIB: begin
            if (PERIODIC_FIX_MODE_I && req_rise)
               pwr_next = GHPC_FIX;
            else if (!PERIODIC_FIX_MODE_I && req_s)
               pwr_next = GHPC_FULL;
         end
         GHPC_FULL: begin
            if (!req_s)
               pwr_next = GHPC_HIB;
         end
         GHPC_FIX: begin
            if (NAV_I.fix_done)
               pwr_next = GHPC_HIB;
         end
         default: pwr_next = GHPC_HIB;
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         pwr_reg       <= GHPC_HIB;
         POWER_STATE_O <= 1'b0;
      end else begin
         pwr_reg       <= pwr_next;
         POWER_STATE_O <= (pwr_next != GHPC_HIB);
      end
   end

   // second pulse and utc message timing; counters are wide for 300ms
   wire       pps_ok = NAV_I.fix3d && (NAV_I.sats >= 6'(MIN_SATS));
   logic [26:0] hi_cnt_reg;
   logic [26:0] msg_cnt_reg;
   logic        msg_arm_reg;
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         SECOND_PULSE_OUT_O <= 1'b0;
         hi_cnt_reg         <= 27'h0;
         msg_cnt_reg        <= 27'h0;
         msg_arm_reg        <= 1'b0;
         UTC_MSG_O          <= 1'b0;
      end else begin
         UTC_MSG_O <= 1'b0;
         if (!pps_ok) begin
            SECOND_PULSE_OUT_O <= 1'b0;
            hi_cnt_reg         <= 27'h0;
         end else if (NAV_I.utc_sec) begin
            SECOND_PULSE_OUT_O <= 1'b1;
            hi_cnt_reg         <= 27'(PULSE_HIGH_CYC - 1);
            msg_cnt_reg        <= 27'(MSG_DELAY_CYC - 1);
            msg_arm_reg        <= 1'b1;
         end else if (hi_cnt_reg != 27'h0) begin
            hi_cnt_reg <= hi_cnt_reg - 27'h1;
         end else begin
            SECOND_PULSE_OUT_O <= 1'b0;
         end
         if (msg_arm_reg && !NAV_I.utc_sec) begin
            if (msg_cnt_reg == 27'h0) begin
               UTC_MSG_O   <= 1'b1;
               msg_arm_reg <= 1'b0;
            end else begin
               msg_cnt_reg <= msg_cnt_reg - 27'h1;
            end
         end
      end
   end

   // boot tests run in fixed order, stay in boot on any failure
   ghpc_boot_t boot_reg;
   ghpc_boot_t boot_next;
   logic       boot_hold_reg;
   always_comb begin
      boot_next = boot_reg;
      case (boot_reg)
         GHPC_B_FLASH: if (FLASH_OK_I) boot_next = GHPC_B_PIN;
         GHPC_B_PIN:   if (!bsel_sync_reg[1]) boot_next = GHPC_B_CRC;
         GHPC_B_CRC:   if (CRC_OK_I) boot_next = GHPC_B_OP;
         GHPC_B_OP:    boot_next = GHPC_B_OP;
         default:      boot_next = GHPC_B_FLASH;
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         boot_reg      <= GHPC_B_FLASH;
         boot_hold_reg <= 1'b0;
         OPERATIONAL_O <= 1'b0;
      end else begin
         // one try per test; a failure parks in boot
         boot_hold_reg <= boot_hold_reg | (boot_next == boot_reg && boot_reg != GHPC_B_OP);
         if (!boot_hold_reg)
            boot_reg <= boot_next;
         OPERATIONAL_O <= (boot_reg == GHPC_B_OP);
      end
   end

   // straps caught once after reset release, port off meanwhile
   logic strap_done_reg;
   logic [1:0] strap_sync_reg;
   logic [1:0] strap_s_reg;
   always_ff @(posedge CLK_I) begin
      strap_sync_reg <= {STRAP_A_I, STRAP_B_I};
      strap_s_reg    <= strap_sync_reg;
   end
   wire [1:0] port_dec = (strap_s_reg == 2'b11) ? GHPC_PORT_UART :
                         (strap_s_reg == 2'b00) ? GHPC_PORT_I2C : GHPC_PORT_SPI;
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         strap_done_reg <= 1'b0;
         PORT_SEL_O     <= GHPC_PORT_SPI;
         PORT_EN_O      <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         PORT_SEL_O     <= port_dec;
         PORT_EN_O      <= 1'b1;
      end
   end

   // configuration command updates uart and i2c settings
   wire cfg_hit = CFG_CMD_I && CFG_MSG_I == CFG_MSG_ID && CFG_SUB_I == CFG_SUB_ID;
   always_ff @(posedge CLK_I) begin
      if (rst) begin
         UART_FLOW_EN_O <= 1'b0;
         I2C_SLAVE_O    <= 1'b0;
         I2C_SLOW_O     <= 1'b0;
         I2C_RX_ADDR_O  <= I2C_RX_ADDR;
         I2C_TX_ADDR_O  <= I2C_TX_ADDR;
      end else if (cfg_hit) begin
         UART_FLOW_EN_O <= 1'b1;
         I2C_SLAVE_O    <= CFG_I2C_SLAVE_I;
         I2C_SLOW_O     <= CFG_I2C_SLOW_I;
         I2C_RX_ADDR_O  <= CFG_I2C_RX_ADDR_I;
         I2C_TX_ADDR_O  <= CFG_I2C_TX_ADDR_I;
      end
   end

   // spi link domain: mode 1, shift out on rise, sample on fall
   // byte-level words cross via toggle plus held data
   logic [2:0] sbit_reg;
   logic [7:0] sin_reg;
   logic [7:0] sout_reg;
   logic [7:0] rxb_reg;
   logic       rx_tgl_reg;
   logic       idle_ph_reg;
   logic [7:0] txb_hold;
   logic       txb_valid;
   logic       tx_ack_tgl_reg;
   logic       link_rst_reg;
   always_ff @(negedge SPI_CLK_I or posedge SPI_CS_N_I) begin
      if (SPI_CS_N_I) begin
         sbit_reg <= 3'h0;
         sin_reg  <= 8'h0;
      end else begin
         sin_reg  <= {sin_reg[6:0], SPI_MOSI_I};
         sbit_reg <= sbit_reg + 3'h1;
      end
   end
   // byte and toggle outlive chip select, so only the port reset clears them
   always_ff @(negedge SPI_CLK_I or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         rxb_reg    <= 8'h0;
         rx_tgl_reg <= 1'b0;
      end else if (!SPI_CS_N_I && sbit_reg == 3'h7) begin
         rxb_reg    <= {sin_reg[6:0], SPI_MOSI_I};
         rx_tgl_reg <= ~rx_tgl_reg;
      end
   end
   // tx byte select: fifo word or idle pattern
   wire [7:0] tx_next_byte = txb_valid ? txb_hold : (idle_ph_reg ? IDLE_B1 : IDLE_B0);
   always_ff @(posedge SPI_CLK_I or posedge SPI_CS_N_I) begin
      if (SPI_CS_N_I) begin
         sout_reg <= 8'h0;
      end else if (sbit_reg == 3'h0) begin
         sout_reg <= tx_next_byte;
      end else begin
         sout_reg <= {sout_reg[6:0], 1'b0};
      end
   end
   // first rising edge of a byte: ack a fifo word or step the pattern
   always_ff @(posedge SPI_CLK_I or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         idle_ph_reg    <= 1'b0;
         tx_ack_tgl_reg <= 1'b0;
      end else if (!SPI_CS_N_I && sbit_reg == 3'h0) begin
         tx_ack_tgl_reg <= tx_ack_tgl_reg ^ txb_valid;
         idle_ph_reg    <= idle_ph_reg ^ ~txb_valid;
      end
   end
   assign SPI_MISO_O = sout_reg[7];  // driven from the rising edge, ready at the fall
   always_ff @(posedge CLK_I) begin
      link_rst_reg  <= rst | SPI_SW_RST_I;  // a flop, released while the link clock rests
      SPI_MISO_OE_O <= ~csn_sync_reg[1] & PORT_EN_O & (PORT_SEL_O == GHPC_PORT_SPI);
   end

   // rx toggle and tx ack toggle crossing into system clock
   logic [2:0] rxt_sync_reg;
   logic [2:0] txa_sync_reg;
   always_ff @(posedge CLK_I) begin
      rxt_sync_reg <= {rxt_sync_reg[1:0], rx_tgl_reg};
      txa_sync_reg <= {txa_sync_reg[1:0], tx_ack_tgl_reg};
   end
   wire rx_evt = rxt_sync_reg[2] ^ rxt_sync_reg[1];
   wire tx_ack = txa_sync_reg[2] ^ txa_sync_reg[1];

   // fifos, 1024 bytes each
   logic [7:0]      tx_mem [SPI_FIFO_DEPTH];
   logic [7:0]      rx_mem [SPI_FIFO_DEPTH];
   logic [SPI_AW:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
   logic [7:0]      idle_cnt_reg;
   logic            rx_gate_reg;
   logic            last_a7_reg;
   wire [SPI_AW:0]  tx_lvl = tx_wp_reg - tx_rp_reg;
   wire [SPI_AW:0]  rx_lvl = rx_wp_reg - rx_rp_reg;
   wire             tx_empty = (tx_lvl == '0);
   wire             is_idle_b1 = last_a7_reg && rxb_reg == IDLE_B1;
   wire             srst = rst | SPI_SW_RST_I;
   // tx head presented held stable while it is valid
   assign txb_hold  = tx_mem[tx_rp_reg[SPI_AW-1:0]];
   assign txb_valid = ~tx_empty;
   always_ff @(posedge CLK_I) begin
      if (TX_WR_I && !TX_FULL_O)
         tx_mem[tx_wp_reg[SPI_AW-1:0]] <= TX_DATA_I;
      if (rx_evt && !rx_gate_reg && rx_lvl != 11'(SPI_FIFO_DEPTH))
         rx_mem[rx_wp_reg[SPI_AW-1:0]] <= rxb_reg;
   end
   always_ff @(posedge CLK_I) begin
      if (srst) begin
         tx_wp_reg    <= '0;
         tx_rp_reg    <= '0;
         rx_wp_reg    <= '0;
         rx_rp_reg    <= '0;
         idle_cnt_reg <= 8'h0;
         rx_gate_reg  <= 1'b0;
         last_a7_reg  <= 1'b0;
         TX_FULL_O    <= 1'b0;
         RX_VALID_O   <= 1'b0;
         RX_DATA_O    <= 8'h0;
         FIFO_IRQ_O   <= 1'b0;
         SYNC_ERR_O   <= 1'b0;
      end else begin
         if (TX_WR_I && !TX_FULL_O)
            tx_wp_reg <= tx_wp_reg + 11'h1;
         if (tx_ack)
            tx_rp_reg <= tx_rp_reg + 11'h1;
         TX_FULL_O <= (tx_lvl >= 11'(SPI_FIFO_DEPTH - 1));
         if (rx_evt) begin
            last_a7_reg <= (rxb_reg == IDLE_B0);
            if (is_idle_b1) begin
               if (idle_cnt_reg >= IDLE_LIMIT_I)
                  rx_gate_reg <= 1'b1;
               else
                  idle_cnt_reg <= idle_cnt_reg + 8'h1;
            end else if (rxb_reg != IDLE_B0) begin
               idle_cnt_reg <= 8'h0;
               rx_gate_reg  <= 1'b0;
            end
            // unexpected b4 without a7 ahead, while rx is gated, marks lost byte sync
            if (rxb_reg == IDLE_B1 && !last_a7_reg && rx_gate_reg)
               SYNC_ERR_O <= 1'b1;
            if (!rx_gate_reg && rx_lvl != 11'(SPI_FIFO_DEPTH))
               rx_wp_reg <= rx_wp_reg + 11'h1;
         end
         RX_VALID_O <= 1'b0;
         if (RX_RD_I && rx_lvl != '0) begin
            RX_DATA_O  <= rx_mem[rx_rp_reg[SPI_AW-1:0]];
            RX_VALID_O <= 1'b1;
            rx_rp_reg  <= rx_rp_reg + 11'h1;
         end
         FIFO_IRQ_O <= (rx_lvl >= FIFO_LEVEL_I) || (tx_lvl <= FIFO_LEVEL_I);
      end
   end
endmodule

// file: ghpc_host_model.sv
`timescale 1ns/1ps
// host side spi master, mode 1, msb first
module ghpc_host_model (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // clock stands still and chip select idles high outside frames
   initial begin
      {sclk_o, mosi_o} = 2'b00;
      // a real deselect edge after start clears the port's bit counter
      #1 cs_n_o = 1'b1;
   end
   // one byte per frame; 48 ns link period
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n_o = 1'b0;
      #24;
      for (int i = 7; i >= 0; i--) begin
         sclk_o = 1'b1;
         mosi_o = tx[i]; // launch on rising edge
         #24;
         sclk_o = 1'b0;
         rx[i] = miso_i; // sample on falling edge
         #24;
      end
      cs_n_o = 1'b1;
      mosi_o = ~tx[0]; // released line must not look like held data
   endtask
endmodule

// file: ghpc_checker_assertions.sv
`timescale 1ns/1ps
// port-level checker for the power, pulse, boot and config logic
module ghpc_checker
   import ghpc_pkg::*;
(
   input wire logic       CLK_I,
   input wire logic       RST_I,
   input wire logic       PWR_REQ_I,
   input wire logic       EXT_RST_N_I,
   input wire logic       PERIODIC_FIX_MODE_I,
   input wire ghpc_nav_t  NAV_I,
   input wire logic       FLASH_OK_I,
   input wire logic       CRC_OK_I,
   input wire logic       BOOT_SELECT_IN_I,
   input wire logic       CFG_CMD_I,
   input wire logic [7:0] CFG_MSG_I,
   input wire logic [7:0] CFG_SUB_I,
   input wire logic       POWER_STATE_O,
   input wire logic       SECOND_PULSE_OUT_O,
   input wire logic       UTC_MSG_O,
   input wire logic       OPERATIONAL_O,
   input wire logic       PORT_EN_O,
   input wire logic       UART_FLOW_EN_O,
   input wire logic [6:0] I2C_RX_ADDR_O,
   input wire logic [6:0] I2C_TX_ADDR_O
);
   logic [31:0] hi_cnt_reg;
   logic [31:0] utc_cnt_reg;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // counters: pulse high time, and time since the utc edge
   always_ff @(posedge CLK_I) begin
      hi_cnt_reg <= (RST_I || !SECOND_PULSE_OUT_O) ? 32'h0 : hi_cnt_reg + 32'h1;
      utc_cnt_reg <= (RST_I || NAV_I.utc_sec) ? 32'h0 : utc_cnt_reg + 32'h1;
   end
   pwr_wake_a: assert property ((PWR_REQ_I && EXT_RST_N_I && !PERIODIC_FIX_MODE_I)[*8]
      |=> POWER_STATE_O) else $error("power state not high under request");
   pwr_sleep_a: assert property ((!PWR_REQ_I && EXT_RST_N_I && !PERIODIC_FIX_MODE_I)[*8]
      |=> !POWER_STATE_O) else $error("power state not low without request");
   ext_reset_a: assert property ((!EXT_RST_N_I)[*4] |=> !POWER_STATE_O)
      else $error("external reset left full power");
   pulse_start_a: assert property (NAV_I.utc_sec && NAV_I.fix3d && NAV_I.sats >= 6'h05
      |-> ##[1:3] SECOND_PULSE_OUT_O) else $error("second pulse missing");
   pulse_nofix_a: assert property ((!NAV_I.fix3d)[*3] |=> !$rose(SECOND_PULSE_OUT_O))
      else $error("second pulse without fix");
   pulse_len_a: assert property (hi_cnt_reg <= PULSE_HIGH_CYC)
      else $error("second pulse too long");
   utc_delay_a: assert property (UTC_MSG_O |-> utc_cnt_reg inside
      {[MSG_DELAY_CYC - 2 : MSG_DELAY_CYC + 2]}) else $error("utc message mistimed");
   boot_pass_a: assert property ($rose(OPERATIONAL_O) |-> FLASH_OK_I && CRC_OK_I
      && !BOOT_SELECT_IN_I) else $error("operational without passing tests");
   port_off_a: assert property (disable iff (1'b0) RST_I |=> !PORT_EN_O)
      else $error("port enabled in reset");
   flow_cmd_a: assert property ($rose(UART_FLOW_EN_O) |-> $past(CFG_CMD_I)
      && $past(CFG_MSG_I) == 8'hb2 && $past(CFG_SUB_I) == 8'h46) else $error("flow on bad cmd");
   i2c_dflt_a: assert property ($fell(RST_I) |-> I2C_RX_ADDR_O == 7'h60
      && I2C_TX_ADDR_O == 7'h62) else $error("i2c default address wrong");
   cover property ($rose(POWER_STATE_O));
   cover property ($rose(SECOND_PULSE_OUT_O));
   cover property ($rose(OPERATIONAL_O));
   cover property ($rose(UART_FLOW_EN_O));
endmodule
bind ghpc_top ghpc_checker ghpc_checker_i (.CLK_I(CLK_I), .RST_I(RST_I), .PWR_REQ_I(PWR_REQ_I),
   .EXT_RST_N_I(EXT_RST_N_I), .PERIODIC_FIX_MODE_I(PERIODIC_FIX_MODE_I), .NAV_I(NAV_I),
   .FLASH_OK_I(FLASH_OK_I), .CRC_OK_I(CRC_OK_I), .BOOT_SELECT_IN_I(BOOT_SELECT_IN_I),
   .CFG_CMD_I(CFG_CMD_I), .CFG_MSG_I(CFG_MSG_I), .CFG_SUB_I(CFG_SUB_I),
   .POWER_STATE_O(POWER_STATE_O), .SECOND_PULSE_OUT_O(SECOND_PULSE_OUT_O),
   .UTC_MSG_O(UTC_MSG_O), .OPERATIONAL_O(OPERATIONAL_O), .PORT_EN_O(PORT_EN_O),
   .UART_FLOW_EN_O(UART_FLOW_EN_O), .I2C_RX_ADDR_O(I2C_RX_ADDR_O), .I2C_TX_ADDR_O(I2C_TX_ADDR_O));

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_top;
   import ghpc_pkg::*;
   logic clk, rst, pwr_req, ext_rst_n, pfm, boot_sel, flash_ok, crc_ok, strap_a, strap_b;
   logic cfg_cmd, cfg_slave, cfg_slow, tx_wr, rx_rd, sclk, cs_n, mosi, miso, pwr_st, pps;
   logic oper, port_en, flow, i2c_slv, i2c_slo, rx_vld, tx_full, irq, sync_err, miso_oe, utc_msg;
   logic [7:0] cfg_msg, cfg_sub, tx_data, rx_b, rx_data, v, e;
   logic [6:0] cfg_rx, cfg_tx, i2c_rx, i2c_tx, x_rx, x_tx;
   logic [1:0] port_sel;
   ghpc_nav_t nav;
   int bad_count, n_compared;
   int q[$];
   ghpc_top ghpc_top_i (.CLK_I(clk), .RST_I(rst), .SPI_CLK_I(sclk), .SPI_CS_N_I(cs_n),
      .SPI_MOSI_I(mosi), .PWR_REQ_I(pwr_req), .EXT_RST_N_I(ext_rst_n),
      .PERIODIC_FIX_MODE_I(pfm), .BOOT_SELECT_IN_I(boot_sel), .FLASH_OK_I(flash_ok),
      .CRC_OK_I(crc_ok), .STRAP_A_I(strap_a), .STRAP_B_I(strap_b), .NAV_I(nav),
      .CFG_CMD_I(cfg_cmd), .CFG_MSG_I(cfg_msg), .CFG_SUB_I(cfg_sub),
      .CFG_I2C_SLAVE_I(cfg_slave), .CFG_I2C_SLOW_I(cfg_slow), .CFG_I2C_RX_ADDR_I(cfg_rx),
      .CFG_I2C_TX_ADDR_I(cfg_tx), .TX_WR_I(tx_wr), .TX_DATA_I(tx_data), .RX_RD_I(rx_rd),
      .IDLE_LIMIT_I(8'hff), .FIFO_LEVEL_I(11'h000), .SPI_SW_RST_I(1'b0), .SPI_MISO_O(miso),
      .SPI_MISO_OE_O(miso_oe), .POWER_STATE_O(pwr_st), .SECOND_PULSE_OUT_O(pps),
      .UTC_MSG_O(utc_msg), .OPERATIONAL_O(oper), .PORT_SEL_O(port_sel), .PORT_EN_O(port_en),
      .UART_FLOW_EN_O(flow), .I2C_SLAVE_O(i2c_slv), .I2C_SLOW_O(i2c_slo),
      .I2C_RX_ADDR_O(i2c_rx), .I2C_TX_ADDR_O(i2c_tx), .TX_FULL_O(tx_full), .RX_VALID_O(rx_vld),
      .RX_DATA_O(rx_data), .FIFO_IRQ_O(irq), .SYNC_ERR_O(sync_err));
   ghpc_host_model host_i (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
   // system clock, 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // wait n edges, then settle past the edge
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic end_sim();
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard, well past the expected run
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
   initial begin
      // reset from time zero, so no edge sees an unknown reset
      rst = 1'b1;
      {pwr_req, pfm, cfg_cmd, tx_wr, rx_rd, cfg_slave, cfg_slow} = '0;
      {ext_rst_n, flash_ok, crc_ok, boot_sel, strap_a, strap_b} = 6'b111001;
      {cfg_msg, cfg_sub, tx_data, cfg_rx, cfg_tx} = '0;
      nav = '0;
      void'($urandom(87));
      // four resets: boot outcomes and strap choices; spi last
      for (int k = 0; k < 4; k++) begin
         // flash fails, pin forces boot, crc fails, then all pass
         @(posedge clk) {flash_ok, boot_sel, crc_ok} <= 3'(12'hb33 >> (3 * k));
         {strap_a, strap_b} <= 2'(8'h53 >> (2 * k));
         rst <= 1'b1;
         wt(4);
         `CHK("port_en", 1'b0, port_en)
         @(posedge clk) rst <= 1'b0;
         wt(10);
         `CHK("oper", k == 3, oper)
         `CHK("port_sel", 2'(8'h09 >> (2 * k)), port_sel)
         `CHK("flow", 1'b0, flow)
         `CHK("i2c_addr", {7'h60, 7'h62}, {i2c_rx, i2c_tx})
      end
      $display("test boot and strap done");
      // power request level, then a long external reset
      @(posedge clk) pwr_req <= 1'b1;
      wt(8);
      `CHK("pwr", 1'b1, pwr_st)
      @(posedge clk) pwr_req <= 1'b0;
      wt(8);
      `CHK("pwr", 1'b0, pwr_st)
      @(posedge clk) pwr_req <= 1'b1;
      wt(8);
      @(posedge clk) ext_rst_n <= 1'b0;
      wt(250);
      `CHK("pwr", 1'b0, pwr_st)
      @(posedge clk) ext_rst_n <= 1'b1;
      wt(12);
      `CHK("pwr", 1'b1, pwr_st)
      @(posedge clk) pwr_req <= 1'b0;
      wt(8);
      $display("test power done");
      // periodic mode: one short request, awake until fix done
      @(posedge clk) {pfm, pwr_req} <= 2'b11;
      wt(3);
      @(posedge clk) pwr_req <= 1'b0;
      wt(10);
      `CHK("pwr", 1'b1, pwr_st)
      @(posedge clk) nav.fix_done <= 1'b1;
      @(posedge clk) nav.fix_done <= 1'b0;
      wt(8);
      `CHK("pwr", 1'b0, pwr_st)
      @(posedge clk) pfm <= 1'b0;
      $display("test periodic done");
      // config command: only id b2 sub 46 takes effect
      for (int k = 0; k < 3; k++) begin
         x_rx = 7'($urandom);
         x_tx = 7'($urandom);
         @(posedge clk) {cfg_msg, cfg_sub} <= 16'(48'hb247_b146_b246 >> (16 * (2 - k)));
         {cfg_cmd, cfg_slave, cfg_slow, cfg_rx, cfg_tx} <= {3'b111, x_rx, x_tx};
         @(posedge clk) cfg_cmd <= 1'b0;
         wt(3);
         `CHK("flow", k == 2, flow)
         `CHK("i2c_mode", {2{k == 2}}, {i2c_slv, i2c_slo})
         `CHK("i2c_rx", (k == 2) ? x_rx : 7'h60, i2c_rx)
         `CHK("i2c_tx", (k == 2) ? x_tx : 7'h62, i2c_tx)
      end
      $display("test config done");
      // second pulse at 4 then 5 satellites
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) {nav.fix3d, nav.sats, nav.utc_sec} <= {1'b1, 6'(4 + k), 1'b1};
         @(posedge clk) nav.utc_sec <= 1'b0;
         wt(4);
         `CHK("pps", k == 1, pps)
         `CHK("utc_msg", 1'b0, utc_msg)
      end
      $display("test second pulse done");
      // wake first; the host's settle time after the power state rises is cut short
      @(posedge clk) pwr_req <= 1'b1;
      wt(8);
      `CHK("pwr", 1'b1, pwr_st)
      // spi: queued bytes out, then idle pattern from the empty fifo
      for (int k = 0; k < 3; k++) begin
         v = 8'($urandom) & 8'h7f;
         q.push_back(v);
         @(posedge clk) {tx_wr, tx_data} <= {1'b1, v};
      end
      @(posedge clk) tx_wr <= 1'b0;
      q.push_back(8'ha7);
      q.push_back(8'hb4);
      wt(10);
      `CHK("tx_full", 1'b0, tx_full)
      while (q.size() > 0) begin
         e = 8'(q.pop_front());
         v = 8'($urandom) & 8'h7f;
         host_i.xfer(v, rx_b);
         `CHK("miso", e, rx_b)
         wt(10);
         `CHK("miso_oe", 1'b0, miso_oe)
         @(posedge clk) rx_rd <= 1'b1;
         @(posedge clk) rx_rd <= 1'b0;
         #1;
         `CHK("rx", {1'b1, v}, {rx_vld, rx_data})
      end
      `CHK("sync_err", 1'b0, sync_err)
      `CHK("irq", 1'b1, irq)
      // only idle bytes came back last: host toggles the power request
      @(posedge clk) pwr_req <= 1'b0;
      wt(8);
      `CHK("pwr", 1'b0, pwr_st)
      @(posedge clk) pwr_req <= 1'b1;
      wt(8);
      `CHK("pwr", 1'b1, pwr_st)
      $display("test spi done");
      end_sim();
   end
endmodule
